// ### ebcb_pkg.sv
// Shared constants and types for the expansion bus command buffer controller
package ebcb_pkg;
	// Core clock period
	localparam int CLK_PERIOD_NS = 10;
	// Address and byte enable settle before a command falls (least time)
	localparam int SETUP_NS = 50;
	// Command strobe width (least time)
	localparam int STROBE_NS = 250;
	// Address hold after a command rises (least time)
	localparam int HOLD_NS = 30;
	// Longest wait for the device to grant the expansion bus
	localparam int AEN_WAIT_NS = 2000;
	// Least times round up, the longest wait rounds down
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AEN_WAIT_CYC = AEN_WAIT_NS / CLK_PERIOD_NS;
	// Phase counter width
	localparam int CNT_W = 8;
	// Synchronised device outputs, bit positions
	localparam int SYNC_W = 5;
	localparam int SY_LOWMEG_RD = 0;
	localparam int SY_LOWMEG_WR = 1;
	localparam int SY_EXTMEM_RD = 2;
	localparam int SY_EXTMEM_WR = 3;
	localparam int SY_ADDR_EN = 4;
	// Active-low levels
	localparam logic ACT_N = 1'b0;
	localparam logic IDLE_N = 1'b1;
	// Who owns a cycle
	typedef enum logic [1:0] {
		OWN_CPU = 2'h0,
		OWN_LDMA = 2'h1,
		OWN_EXP = 2'h2,
		OWN_SPARE = 2'h3
	} ebcb_owner_t;
	// Cycle sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_GRANT = 5'h02,
		ST_SETUP = 5'h04,
		ST_STROBE = 5'h08,
		ST_HOLD = 5'h10
	} ebcb_state_t;
endpackage

// ### ebcb_sync_if.sv
// Carrier between the controller and its input synchroniser
`timescale 1ns/1ps
`default_nettype none
interface ebcb_sync_if;
	import ebcb_pkg::*;
	logic [SYNC_W-1:0] raw; // Pin levels straight from the device
	logic [SYNC_W-1:0] synced; // Same levels after two flops
	modport ctrl (output raw, input synced);
	modport sync (input raw, output synced);
endinterface
`default_nettype wire

// ### ebcb_sync.sv
// Two-flop synchroniser for the device's asynchronous outputs
`timescale 1ns/1ps
`default_nettype none
module ebcb_sync (
	input wire logic clk, // Core clock
	input wire logic rst, // Asynchronous reset, active high
	ebcb_sync_if.sync bus // Raw in, synced out
);
	import ebcb_pkg::*;
	logic [SYNC_W-1:0] meta_q; // First stage, read only by the second
	logic [SYNC_W-1:0] sync_q; // Second stage
	// Idle level of every watched pin is high, so reset to high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= bus.raw;
			sync_q <= meta_q;
		end
	end
	assign bus.synced = sync_q;
endmodule
`default_nettype wire

// ### ebcb_ctrl.sv
// Controller that runs local and expansion cycles through the command buffer
// Contract
// (R1) Low-meg commands only below one megabyte
// (R2) Extended memory read on every read
// (R3) Extended memory write on every write
// (R4) Port commands two-way; expansion DMA drives them
// (R5) Device drives expansion bit 0 for CPU
// (R6) Expansion master drives bit 0 once granted
// (R7) Local DMA drives local address bit 0
// (R8) Processor drives local bit 0 on reads
// (R9) Expansion high byte enable driven by owner
// (R10) Local high byte enable driven by owner
// (R11) Bus controller supplies memory read/write strobes
// (R12) Bus controller supplies port read/write strobes
// (R13) Device passes DMA commands when enable low
// (R14) Device pulls address enable low on grant
// (R15) Device never fights the cycle owner
`timescale 1ns/1ps
`default_nettype none
module ebcb_ctrl (
	input wire logic CORE_CLK, // Core clock, 100 MHz
	input wire logic RESET, // Asynchronous reset, active high
	input wire logic REQ_VALID, // Start a cycle, taken when ready
	input wire ebcb_pkg::ebcb_owner_t REQ_OWNER, // Cycle owner
	input wire logic REQ_IS_PORT, // 1 port cycle, 0 memory cycle
	input wire logic REQ_WRITE, // 1 write, 0 read
	input wire logic REQ_ADDR0, // Address bit 0
	input wire logic REQ_HIGH, // Upper data byte used
	output logic REQ_READY, // Idle, next request taken
	output logic DONE, // One-cycle pulse at cycle end
	output logic TIMEOUT, // Last cycle was an expansion cycle that got no grant; any take clears it
	output logic SEEN_LOWMEG, // Low-meg command seen in last strobe
	output logic SEEN_EXTMEM, // Extended memory command seen in last strobe
	output logic CPU_MEMORY_READ_N, // Local memory read strobe
	output logic CPU_MEMORY_WRITE_N, // Local memory write strobe
	output logic CPU_PORT_READ_N, // Local port read strobe
	output logic CPU_PORT_WRITE_N, // Local port write strobe
	output logic DMA_CMD_DRIVE_EN_N, // Low while local DMA owns the cycle
	input wire logic LOCAL_ADDR_BIT0_I, // Local bit 0, pin level
	output logic LOCAL_ADDR_BIT0_O, // Local bit 0, driven value
	output logic LOCAL_ADDR_BIT0_OE, // Local bit 0, drive enable
	input wire logic LOCAL_HIGH_BYTE_EN_N_I, // Local high byte enable, pin level
	output logic LOCAL_HIGH_BYTE_EN_N_O, // Local high byte enable, value
	output logic LOCAL_HIGH_BYTE_EN_N_OE, // Local high byte enable, drive enable
	input wire logic EXP_ADDR_BIT0_I, // Expansion bit 0, pin level
	output logic EXP_ADDR_BIT0_O, // Expansion bit 0, value
	output logic EXP_ADDR_BIT0_OE, // Expansion bit 0, drive enable
	input wire logic EXP_HIGH_BYTE_EN_N_I, // Expansion high byte enable, pin level
	output logic EXP_HIGH_BYTE_EN_N_O, // Expansion high byte enable, value
	output logic EXP_HIGH_BYTE_EN_N_OE, // Expansion high byte enable, drive enable
	input wire logic EXP_PORT_READ_CMD_N_I, // Expansion port read, pin level
	output logic EXP_PORT_READ_CMD_N_O, // Expansion port read, value
	output logic EXP_PORT_READ_CMD_N_OE, // Expansion port read, drive enable
	input wire logic EXP_PORT_WRITE_CMD_N_I, // Expansion port write, pin level
	output logic EXP_PORT_WRITE_CMD_N_O, // Expansion port write, value
	output logic EXP_PORT_WRITE_CMD_N_OE, // Expansion port write, drive enable
	input wire logic LOWMEG_READ_CMD_N, // Device low-meg read
	input wire logic LOWMEG_WRITE_CMD_N, // Device low-meg write
	input wire logic EXT_MEMORY_READ_CMD_N, // Device extended memory read
	input wire logic EXT_MEMORY_WRITE_CMD_N, // Device extended memory write
	input wire logic ADDRESS_ENABLE_OUT_N // Device grant, low for expansion master
);
	import ebcb_pkg::*;

	// Read-back levels of our own two-way pins are not needed by the sequencer
	ebcb_sync_if sif ();
	ebcb_sync u_sync (
		.clk(CORE_CLK),
		.rst(RESET),
		.bus(sif)
	);
	// Gather the device outputs in one process, so the vector has a single driver
	always_comb begin
		sif.raw = '1;
		sif.raw[SY_LOWMEG_RD] = LOWMEG_READ_CMD_N;
		sif.raw[SY_LOWMEG_WR] = LOWMEG_WRITE_CMD_N;
		sif.raw[SY_EXTMEM_RD] = EXT_MEMORY_READ_CMD_N;
		sif.raw[SY_EXTMEM_WR] = EXT_MEMORY_WRITE_CMD_N;
		sif.raw[SY_ADDR_EN] = ADDRESS_ENABLE_OUT_N;
	end

	ebcb_state_t st_q, st_d; // Sequencer state
	logic [CNT_W-1:0] cnt_q, cnt_d; // Cycles spent in this state
	ebcb_owner_t own_q, own_d; // Latched request
	logic port_q, port_d, wr_q, wr_d, a0_q, a0_d, high_q, high_d;
	logic tout_q, tout_d; // Grant never came
	logic lowmeg_q, lowmeg_d, extmem_q, extmem_d; // Sticky observations

	// Decode of the synchronised device outputs
	wire aen_low = (sif.synced[SY_ADDR_EN] == ACT_N);
	wire lowmeg_any = (sif.synced[SY_LOWMEG_RD] == ACT_N) || (sif.synced[SY_LOWMEG_WR] == ACT_N);
	wire extmem_any = (sif.synced[SY_EXTMEM_RD] == ACT_N) || (sif.synced[SY_EXTMEM_WR] == ACT_N);

	// Phase end detection, one limit per state
	wire setup_end = (cnt_q == CNT_W'(SETUP_CYC - 1));
	wire strobe_end = (cnt_q == CNT_W'(STROBE_CYC - 1));
	wire hold_end = (cnt_q == CNT_W'(HOLD_CYC - 1));
	wire grant_end = (cnt_q == CNT_W'(AEN_WAIT_CYC - 1));
	wire take = (st_q == ST_IDLE) && REQ_VALID;

	// Next state; an expansion master waits for the device's grant first
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (REQ_VALID) begin
					st_d = (REQ_OWNER == OWN_EXP) ? ST_GRANT : ST_SETUP;
				end
			end
			ST_GRANT: begin
				if (aen_low) begin // [R14]
					st_d = ST_SETUP;
				end else if (grant_end) begin
					st_d = ST_HOLD;
				end
			end
			ST_SETUP: begin
				if (setup_end) begin
					st_d = ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (strobe_end) begin
					st_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (hold_end) begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// Counter restarts on every state change
	assign cnt_d = (st_d != st_q) ? '0 : cnt_q + CNT_W'(1);
	// Request is latched once, at the take
	assign own_d = take ? REQ_OWNER : own_q;
	assign port_d = take ? REQ_IS_PORT : port_q;
	assign wr_d = take ? REQ_WRITE : wr_q;
	assign a0_d = take ? REQ_ADDR0 : a0_q;
	assign high_d = take ? REQ_HIGH : high_q;
	assign tout_d = take ? 1'b0 : (tout_q || ((st_q == ST_GRANT) && grant_end && !aen_low));
	// Device commands seen while our strobe is out; a new take clears them
	assign lowmeg_d = take ? 1'b0 : (lowmeg_q || ((st_q == ST_STROBE) && lowmeg_any));
	assign extmem_d = take ? 1'b0 : (extmem_q || ((st_q == ST_STROBE) && extmem_any));

	// Pin drive decode from the next state, so every pin output is a flop
	wire is_exp = (own_d == OWN_EXP);
	wire is_ldma = (own_d == OWN_LDMA);
	wire is_local = !is_exp; // CPU, local DMA, and the spare code treated as CPU
	wire phase_d = ((st_d == ST_SETUP) || (st_d == ST_STROBE) || (st_d == ST_HOLD)) && !tout_d;
	wire strobe_d = (st_d == ST_STROBE);
	wire loc_cmd = strobe_d && is_local;
	// Local bit 0: DMA drives it, the processor drives it for its cycles
	wire loc_oe_d = phase_d && is_local; // [R7] [R8] [R10]
	// Expansion side belongs to us only as a granted master
	wire exp_oe_d = phase_d && is_exp; // [R6] [R9]
	wire exp_port_oe_d = exp_oe_d && port_d; // [R4]

	// Sequencer and request registers
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			st_q <= ST_IDLE;
			cnt_q <= '0;
			own_q <= OWN_CPU;
			{port_q, wr_q, a0_q, high_q} <= 4'h0;
			{tout_q, lowmeg_q, extmem_q} <= 3'h0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			own_q <= own_d;
			{port_q, wr_q, a0_q, high_q} <= {port_d, wr_d, a0_d, high_d};
			{tout_q, lowmeg_q, extmem_q} <= {tout_d, lowmeg_d, extmem_d};
		end
	end

	// Local command strobes; only one is ever low
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			CPU_MEMORY_READ_N <= IDLE_N;
			CPU_MEMORY_WRITE_N <= IDLE_N;
			CPU_PORT_READ_N <= IDLE_N;
			CPU_PORT_WRITE_N <= IDLE_N;
			DMA_CMD_DRIVE_EN_N <= IDLE_N;
		end else begin
			CPU_MEMORY_READ_N <= !(loc_cmd && !port_d && !wr_d); // [R11]
			CPU_MEMORY_WRITE_N <= !(loc_cmd && !port_d && wr_d); // [R11]
			CPU_PORT_READ_N <= !(loc_cmd && port_d && !wr_d); // [R12]
			CPU_PORT_WRITE_N <= !(loc_cmd && port_d && wr_d); // [R12]
			DMA_CMD_DRIVE_EN_N <= !(phase_d && is_ldma); // [R7]
		end
	end

	// Two-way pins: released in reset and between cycles
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			{LOCAL_ADDR_BIT0_OE, LOCAL_HIGH_BYTE_EN_N_OE} <= 2'h0;
			{EXP_ADDR_BIT0_OE, EXP_HIGH_BYTE_EN_N_OE} <= 2'h0;
			{EXP_PORT_READ_CMD_N_OE, EXP_PORT_WRITE_CMD_N_OE} <= 2'h0;
			{LOCAL_ADDR_BIT0_O, EXP_ADDR_BIT0_O} <= 2'h0;
			{LOCAL_HIGH_BYTE_EN_N_O, EXP_HIGH_BYTE_EN_N_O} <= 2'h3;
			{EXP_PORT_READ_CMD_N_O, EXP_PORT_WRITE_CMD_N_O} <= 2'h3;
		end else begin
			{LOCAL_ADDR_BIT0_OE, LOCAL_HIGH_BYTE_EN_N_OE} <= {2{loc_oe_d}}; // [R7] [R10]
			{EXP_ADDR_BIT0_OE, EXP_HIGH_BYTE_EN_N_OE} <= {2{exp_oe_d}}; // [R6] [R9]
			{EXP_PORT_READ_CMD_N_OE, EXP_PORT_WRITE_CMD_N_OE} <= {2{exp_port_oe_d}}; // [R4]
			{LOCAL_ADDR_BIT0_O, EXP_ADDR_BIT0_O} <= {2{a0_d}};
			{LOCAL_HIGH_BYTE_EN_N_O, EXP_HIGH_BYTE_EN_N_O} <= {2{!high_d}}; // [R9] [R10]
			// Value stays high unless we own the port cycle, so a later enable never
			// exposes a stale low command
			EXP_PORT_READ_CMD_N_O <= !(strobe_d && exp_port_oe_d && !wr_d); // [R4]
			EXP_PORT_WRITE_CMD_N_O <= !(strobe_d && exp_port_oe_d && wr_d); // [R4]
		end
	end

	// User-side status
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			{REQ_READY, DONE, TIMEOUT} <= 3'h0;
			{SEEN_LOWMEG, SEEN_EXTMEM} <= 2'h0;
		end else begin
			REQ_READY <= (st_d == ST_IDLE);
			DONE <= (st_q == ST_HOLD) && hold_end;
			TIMEOUT <= tout_d;
			{SEEN_LOWMEG, SEEN_EXTMEM} <= {lowmeg_d, extmem_d};
		end
	end

	// Checks on what this controller drives
	localparam int A_STROBE = STROBE_CYC;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	sequence s_mem_rd_open;
		$fell(CPU_MEMORY_READ_N);
	endsequence
	sequence s_mem_wr_open;
		$fell(CPU_MEMORY_WRITE_N);
	endsequence

	exp_port_own_a: assert property (EXP_PORT_READ_CMD_N_OE |-> own_q == OWN_EXP && port_q) // [R4]
		else $error("expansion port command driven outside an expansion port cycle");
	exp_port_lone_a: assert property (!EXP_PORT_READ_CMD_N_O |-> EXP_PORT_READ_CMD_N_OE && CPU_PORT_READ_N) // [R4]
		else $error("expansion port read low while not owned");
	exp_grant_a: assert property ($rose(EXP_ADDR_BIT0_OE) |-> $past(aen_low)) // [R6]
		else $error("expansion bit 0 driven before the grant");
	dma_addr_a: assert property (own_q == OWN_LDMA && st_q == ST_STROBE |=> LOCAL_ADDR_BIT0_OE && !DMA_CMD_DRIVE_EN_N) // [R7]
		else $error("local DMA cycle without bit 0 drive");
	cpu_rd_addr_a: assert property (!CPU_MEMORY_READ_N |-> LOCAL_ADDR_BIT0_OE && LOCAL_ADDR_BIT0_O == a0_q) // [R8]
		else $error("processor read without its bit 0");
	exp_hbe_a: assert property (EXP_HIGH_BYTE_EN_N_OE |-> EXP_HIGH_BYTE_EN_N_O == !high_q && !LOCAL_HIGH_BYTE_EN_N_OE) // [R9]
		else $error("expansion high byte enable wrong");
	local_hbe_a: assert property ($fell(CPU_PORT_WRITE_N) |-> $past(LOCAL_HIGH_BYTE_EN_N_OE) && LOCAL_HIGH_BYTE_EN_N_O == !high_q) // [R10] [R12]
		else $error("local high byte enable not set up before strobe");
	mem_rd_width_a: assert property (s_mem_rd_open |-> ##A_STROBE $rose(CPU_MEMORY_READ_N)) // [R11]
		else $error("memory read strobe width wrong");
	mem_wr_width_a: assert property (s_mem_wr_open |-> ##A_STROBE $rose(CPU_MEMORY_WRITE_N)) // [R11]
		else $error("memory write strobe width wrong");
endmodule
`default_nettype wire

// ### ebcb_dev_model.sv
// Behavioural model of the command buffer device that faces the controller
`timescale 1ns/1ps
`default_nettype none
module ebcb_dev_model (
	input wire logic BELOW_1M, // Current address lies in the low megabyte
	input wire logic GRANT_REQ, // Another expansion master asks for the bus
	input wire logic MEM_RD_N, // Local memory read strobe
	input wire logic MEM_WR_N, // Local memory write strobe
	input wire logic A0_OE, // Controller drives expansion bit 0
	input wire logic A0_O, // Value the controller drives
	input wire logic LOCAL_A0_OE, // Controller drives local bit 0
	input wire logic LOCAL_A0, // Local bit 0 value
	output logic A0_PIN, // Resolved expansion bit 0 level
	output logic LOWMEG_RD_N, // Low-meg read command
	output logic LOWMEG_WR_N, // Low-meg write command
	output logic EXT_RD_N, // Extended memory read command
	output logic EXT_WR_N, // Extended memory write command
	output logic AEN_N // Address enable, low while a master holds the bus
);
	logic last_a0; // Last level the controller drove on bit 0
	initial last_a0 = 1'b0;
	// Remember the driven level so a released line shows its inverse
	always @(A0_OE or A0_O) begin
		if (A0_OE) begin
			last_a0 = A0_O;
		end
	end
	// Released bit 0 outside local cycles shows the inverse of the last level the controller drove
	// In local cycles the device copies local bit 0 onto the expansion side
	assign A0_PIN = A0_OE ? A0_O : (LOCAL_A0_OE ? LOCAL_A0 : ~last_a0);
	// Low-meg commands follow the local strobes only below one megabyte
	assign LOWMEG_RD_N = MEM_RD_N | ~BELOW_1M;
	assign LOWMEG_WR_N = MEM_WR_N | ~BELOW_1M;
	// Extended commands follow every memory cycle whatever the address
	assign EXT_RD_N = MEM_RD_N;
	assign EXT_WR_N = MEM_WR_N;
	// Grant is shown by pulling address enable low
	assign AEN_N = ~GRANT_REQ;
endmodule
`default_nettype wire

// ### ebcb_ctrl_tb_top.sv
// Self-checking testbench for the expansion bus command buffer controller
`timescale 1ns/1ps
`default_nettype none
module ebcb_ctrl_tb_top;
	import ebcb_pkg::*;
	localparam int BODY = SETUP_CYC + STROBE_CYC + HOLD_CYC; // Driven span of a cycle
	localparam int TMO = 6000; // Whole run needs well under this
	logic clk, rst, valid, is_port, write, a0, high, ready, done, tmo, s_low, s_ext, below, grant;
	ebcb_owner_t owner;
	logic mr_n, mw_n, pr_n, pw_n, dma_n, la0_o, la0_oe, lhb_o, lhb_oe, ea0_o, ea0_oe, ea0_pin;
	logic ehb_o, ehb_oe, pr_o, pr_oe, pw_o, pw_oe, lm_rd, lm_wr, em_rd, em_wr, aen_n;
	logic la0_v, lhb_v, ea0_v, ehb_v; // Values seen while driven
	logic sa0_v; // Expansion bit 0 level seen in local cycles
	logic [3:0] smask; // Local strobes seen low
	int num_errors, cmp_count, cyc, lat, n_str, n_exp, n_dma, n_loe, n_eoe;
	ebcb_ctrl ebcb_ctrl_i (.CORE_CLK(clk), .RESET(rst), .REQ_VALID(valid), .REQ_OWNER(owner),
		.REQ_IS_PORT(is_port), .REQ_WRITE(write), .REQ_ADDR0(a0), .REQ_HIGH(high),
		.REQ_READY(ready), .DONE(done), .TIMEOUT(tmo), .SEEN_LOWMEG(s_low), .SEEN_EXTMEM(s_ext),
		.CPU_MEMORY_READ_N(mr_n), .CPU_MEMORY_WRITE_N(mw_n), .CPU_PORT_READ_N(pr_n),
		.CPU_PORT_WRITE_N(pw_n), .DMA_CMD_DRIVE_EN_N(dma_n),
		.LOCAL_ADDR_BIT0_I(la0_oe ? la0_o : ~a0), .LOCAL_ADDR_BIT0_O(la0_o),
		.LOCAL_ADDR_BIT0_OE(la0_oe), .LOCAL_HIGH_BYTE_EN_N_I(lhb_oe ? lhb_o : 1'b1),
		.LOCAL_HIGH_BYTE_EN_N_O(lhb_o), .LOCAL_HIGH_BYTE_EN_N_OE(lhb_oe),
		.EXP_ADDR_BIT0_I(ea0_pin), .EXP_ADDR_BIT0_O(ea0_o), .EXP_ADDR_BIT0_OE(ea0_oe),
		.EXP_HIGH_BYTE_EN_N_I(ehb_oe ? ehb_o : 1'b1), .EXP_HIGH_BYTE_EN_N_O(ehb_o),
		.EXP_HIGH_BYTE_EN_N_OE(ehb_oe), .EXP_PORT_READ_CMD_N_I(pr_oe ? pr_o : 1'b1),
		.EXP_PORT_READ_CMD_N_O(pr_o), .EXP_PORT_READ_CMD_N_OE(pr_oe),
		.EXP_PORT_WRITE_CMD_N_I(pw_oe ? pw_o : 1'b1), .EXP_PORT_WRITE_CMD_N_O(pw_o),
		.EXP_PORT_WRITE_CMD_N_OE(pw_oe), .LOWMEG_READ_CMD_N(lm_rd), .LOWMEG_WRITE_CMD_N(lm_wr),
		.EXT_MEMORY_READ_CMD_N(em_rd), .EXT_MEMORY_WRITE_CMD_N(em_wr), .ADDRESS_ENABLE_OUT_N(aen_n));
	ebcb_dev_model ebcb_dev_model_i (.BELOW_1M(below), .GRANT_REQ(grant), .MEM_RD_N(mr_n),
		.MEM_WR_N(mw_n), .A0_OE(ea0_oe), .A0_O(ea0_o), .LOCAL_A0_OE(la0_oe), .LOCAL_A0(la0_o),
		.A0_PIN(ea0_pin), .LOWMEG_RD_N(lm_rd),
		.LOWMEG_WR_N(lm_wr), .EXT_RD_N(em_rd), .EXT_WR_N(em_wr), .AEN_N(aen_n));
	// Free-running core clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Compare one value and count it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// Print counts and verdict, then stop
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Present one request and watch the pins until the end pulse
	task automatic run(input ebcb_owner_t o, input logic p, input logic w, input logic ad,
		input logic h);
		int n;
		n = 0;
		lat = 1;
		{n_str, n_exp, n_dma, n_loe, n_eoe} = '0;
		smask = 4'h0;
		// No request before the controller reports ready
		while (ready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		owner = o;
		is_port = p;
		write = w;
		a0 = ad;
		high = h;
		valid = 1'b1;
		@(negedge clk);
		valid = 1'b0;
		// Bounded watch; a missing pulse shows up as a wrong latency
		while (done !== 1'b1 && lat < 400) begin
			if (!(mr_n & mw_n & pr_n & pw_n)) n_str++;
			smask = smask | ~{mr_n, mw_n, pr_n, pw_n};
			if ((pw_oe && !pw_o) || (pr_oe && !pr_o)) n_exp++;
			if (!dma_n) n_dma++;
			if (la0_oe) begin
				n_loe++;
				{la0_v, lhb_v} = {la0_o, lhb_o};
				sa0_v = ea0_pin;
			end
			if (ea0_oe) begin
				n_eoe++;
				{ea0_v, ehb_v} = {ea0_o, ehb_o};
			end
			@(negedge clk);
			lat++;
		end
	endtask
	// Processor memory read in the low megabyte, upper byte used
	task automatic t_cpu_read_low;
		below = 1'b1;
		run(OWN_CPU, 1'b0, 1'b0, 1'b1, 1'b1);
		check(lat, BODY + 1);
		check(n_str, STROBE_CYC);
		check(smask, 4'h8);
		check({s_low, s_ext}, 2'b11);
		check({la0_v, lhb_v}, 2'b10);
		check(n_loe, BODY);
		check(sa0_v, 1'b1);
		check(n_eoe, 0);
		$display("test cpu read low done");
	endtask
	// Spare-code memory write, handled as a processor cycle, above the low megabyte, back to back
	task automatic t_cpu_write_high;
		below = 1'b0;
		run(OWN_SPARE, 1'b0, 1'b1, 1'b0, 1'b0);
		check(smask, 4'h4);
		check({s_low, s_ext}, 2'b01);
		check({la0_v, lhb_v}, 2'b01);
		check(sa0_v, 1'b0);
		$display("test cpu write high done");
	endtask
	// Processor port read gives no memory command at all
	task automatic t_cpu_port_read;
		below = 1'b1;
		run(OWN_CPU, 1'b1, 1'b0, 1'b0, 1'b0);
		check(smask, 4'h2);
		check({s_low, s_ext}, 2'b00);
		$display("test cpu port read done");
	endtask
	// Local DMA port write passes through with the drive enable low
	task automatic t_dma_port_write;
		run(OWN_LDMA, 1'b1, 1'b1, 1'b1, 1'b0);
		check(smask, 4'h1);
		check(n_dma, BODY);
		check(n_str, STROBE_CYC);
		$display("test dma port write done");
	endtask
	// Granted expansion port write drives the two-way pins
	task automatic t_exp_granted;
		grant = 1'b1;
		run(OWN_EXP, 1'b1, 1'b1, 1'b1, 1'b1);
		check(n_exp, STROBE_CYC);
		check(n_eoe, BODY);
		check({ea0_v, ehb_v}, 2'b10);
		check(n_loe, 0);
		check(tmo, 0);
		check(lat < 400, 1);
		// Granted port read, lower byte only
		run(OWN_EXP, 1'b1, 1'b0, 1'b0, 1'b0);
		check(n_exp, STROBE_CYC);
		check({ea0_v, ehb_v}, 2'b01);
		check(n_str, 0);
		// Let the released grant pass the controller's synchroniser before the next request
		grant = 1'b0;
		repeat (3) @(negedge clk);
		$display("test expansion granted done");
	endtask
	// Expansion cycle with no grant must drive nothing and time out
	task automatic t_exp_no_grant;
		grant = 1'b0;
		run(OWN_EXP, 1'b1, 1'b0, 1'b0, 1'b0);
		check(n_eoe, 0);
		check(n_exp, 0);
		check(n_loe, 0);
		check({tmo, lat < 400}, 2'b11);
		$display("test expansion no grant done");
	endtask
	// Hang guard
	initial begin
		cyc = 0;
		forever begin
			@(posedge clk);
			cyc++;
			if (cyc == TMO) begin
				num_errors++;
				tally_and_finish();
			end
		end
	end
	// Main sequence
	initial begin
		{valid, is_port, write, a0, high, below, grant} = '0;
		owner = OWN_CPU;
		num_errors = 0;
		cmp_count = 0;
		rst = 1'b1;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_cpu_read_low();
		t_cpu_write_high();
		t_cpu_port_read();
		t_dma_port_write();
		t_exp_granted();
		t_exp_no_grant();
		tally_and_finish();
	end
endmodule
`default_nettype wire
